// [design/fdhp_drive_scan.sv]
// drive select poll scanner of the embedded disk controller chip
`timescale 1ns/1ns
`default_nettype none
`include "fdhp_params.svh"

module fdhp_drive_scan
  import fdhp_pkg::*;
(
  // clock and reset
  input  wire logic       mclk_i,
  input  wire logic       rst_i,
  // drive select lines and poll step strobe
  output logic [1:0]      drive_sel_o,
  output logic            scan_step_o
);

  localparam logic [11:0] SCAN_LAST = 12'(`FDHP_SCAN_CYCLES - 1);

  fdhp_scan_t st;
  fdhp_scan_t next_st;

  // divider makes a one cycle step enable; poll runs even when idle
  always_comb
  begin
    next_st      = st;
    next_st.step = 1'b0;
    if (st.cnt == SCAN_LAST)
    begin
      next_st.cnt  = 12'h000;
      next_st.step = 1'b1;
      next_st.sel  = st.sel + 2'h1;
    end
    else
    begin
      next_st.cnt = st.cnt + 12'h001;
    end
  end

  // state register
  always_ff @(posedge mclk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      st <= '0;
    end
    else
    begin
      st <= next_st;
    end
  end

  assign drive_sel_o = st.sel;
  assign scan_step_o = st.step;

endmodule
`default_nettype wire

// [design/fdhp_params.svh]
// constants for the floppy dma host port block
`ifndef FDHP_PARAMS_SVH
`define FDHP_PARAMS_SVH

// relative port numbers inside the four port block
`define FDHP_PORT_MAIN_STATUS 2'h0
`define FDHP_PORT_DATA        2'h1
`define FDHP_PORT_IRQ_DMA     2'h2
`define FDHP_PORT_SERIAL      2'h3

// field positions
`define FDHP_BIT_D7           7
`define FDHP_BIT_D0           0
`define FDHP_BASE_MSB         7
`define FDHP_BASE_LSB         2

// interrupt jumper codes: 0..7 vectored lines, 8 general line, above none
`define FDHP_ROUTE_GENERAL    4'h8

// reset values
`define FDHP_RST_ROM_EN       1'b1
`define FDHP_RST_SER_LATCH    1'b0
`define FDHP_RST_TXD          1'b1

// timing: drive poll step of the scanner
`define FDHP_CLK_HZ           25000000
`define FDHP_SCAN_US          100
// cycles per microsecond first, so the product stays inside 32 bits
`define FDHP_SCAN_CYCLES      (`FDHP_SCAN_US * (`FDHP_CLK_HZ / 1000000))

`endif

// [design/fdhp_pkg.sv]
// types for the floppy dma host port block
package fdhp_pkg;

  // access phase of the host port block
  typedef enum logic [0:0]
  {
    FDHP_IDLE   = 1'b0,
    FDHP_ACCESS = 1'b1
  } fdhp_phase_t;

  // host i/o request, one cycle strobes
  typedef struct packed
  {
    logic       rd;
    logic       wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } fdhp_io_req_t;

  // strobes toward the embedded disk controller chip
  typedef struct packed
  {
    logic       cs;
    logic       rd;
    logic       wr;
    logic       a0;
    logic [7:0] wdata;
  } fdhp_chip_bus_t;

  // state of the host port block apart from the drive poll scanner
  typedef struct packed
  {
    fdhp_phase_t    phase;
    logic           rd_pend;
    logic [1:0]     port;
    logic [7:0]     rdata;
    logic           rdata_valid;
    fdhp_chip_bus_t chip;
    logic [23:0]    dma_addr;
    logic           ser_latch;
    logic           rom_en;
    logic           txd;
    logic           motor_on;
    logic [7:0]     vect_irq;
    logic           gen_irq;
  } fdhp_state_t;

  // state of the drive poll scanner
  typedef struct packed
  {
    logic [11:0] cnt;
    logic [1:0]  sel;
    logic        step;
  } fdhp_scan_t;

endpackage

// [design/fdhp_ports.sv]
// host i/o port block of the dma floppy controller board
`timescale 1ns/1ns
`default_nettype none
`include "fdhp_params.svh"

module fdhp_ports
  import fdhp_pkg::*;
(
  // clock and reset
  input  wire logic          mclk_i,
  input  wire logic          rst_i,
  // host i/o bus
  input  wire fdhp_io_req_t  io_req_i,
  output logic [7:0]         io_rdata_o,
  output logic               io_rdata_valid_o,
  output logic               io_busy_o,
  // board configuration
  input  wire logic [5:0]    address_switch_bank_on_i,
  input  wire logic          motor_select_switch_on_i,
  input  wire logic [3:0]    irq_route_sel_i,
  // embedded disk controller chip
  output fdhp_chip_bus_t     disk_controller_chip_o,
  input  wire logic [7:0]    disk_controller_chip_rdata_i,
  input  wire logic          disk_chip_irq_i,
  output logic [1:0]         drive_sel_o,
  output logic               scan_step_o,
  // dma address and startup rom
  output logic [23:0]        dma_addr_o,
  output logic               startup_rom_en_o,
  // serial line and motor
  input  wire logic          serial_rxd_i,
  output logic               serial_txd_o,
  output logic               motor_on_o,
  // bus interrupt lines, active high here
  output logic [7:0]         vect_irq_o,
  output logic               gen_irq_o
);

  fdhp_state_t st;
  fdhp_state_t next_st;

  // base compare: a closed switch reads as zero in the address
  function automatic logic fdhp_hit(input logic [7:0] addr, input logic [5:0] sw_on);
    fdhp_hit = (addr[`FDHP_BASE_MSB:`FDHP_BASE_LSB] == ~sw_on);
  endfunction

  // jumper decode of the chip interrupt onto one bus line
  function automatic logic [8:0] fdhp_route(input logic [3:0] sel, input logic irq);
    logic [8:0] lines;
    lines = 9'h000;
    if (sel < `FDHP_ROUTE_GENERAL)
    begin
      lines[sel[2:0]] = irq;
    end
    else if (sel == `FDHP_ROUTE_GENERAL)
    begin
      lines[8] = irq;
    end
    fdhp_route = lines;
  endfunction

  logic       req_hit;
  logic [1:0] req_port;
  logic [8:0] route_lines;

  // only i/o strobes are decoded; the block never answers memory cycles
  assign req_hit     = fdhp_hit(io_req_i.addr, address_switch_bank_on_i);
  assign req_port    = io_req_i.addr[1:0];
  assign route_lines = fdhp_route(irq_route_sel_i, disk_chip_irq_i);

  // next state: take a request in idle, finish it one cycle later
  always_comb
  begin
    next_st             = st;
    next_st.rdata_valid = 1'b0;
    next_st.chip.cs     = 1'b0;
    next_st.chip.rd     = 1'b0;
    next_st.chip.wr     = 1'b0;
    next_st.vect_irq    = route_lines[7:0];
    next_st.gen_irq     = route_lines[8];

    case (st.phase)
      FDHP_IDLE:
      begin
        if (req_hit && (io_req_i.rd || io_req_i.wr))
        begin
          next_st.phase   = FDHP_ACCESS;
          next_st.port    = req_port;
          next_st.rd_pend = io_req_i.rd;
          if (io_req_i.rd)
          begin
            // ports 0 and 1 read the chip; a0 picks status or data
            if (req_port == `FDHP_PORT_MAIN_STATUS || req_port == `FDHP_PORT_DATA)
            begin
              next_st.chip.cs = 1'b1;
              next_st.chip.rd = 1'b1;
              next_st.chip.a0 = req_port[0];
            end
          end
          else
          begin
            case (req_port)
              `FDHP_PORT_MAIN_STATUS:
              begin
                // status is read only, so a write is dropped here
                next_st.phase = FDHP_ACCESS;
              end
              `FDHP_PORT_DATA:
              begin
                next_st.chip.cs    = 1'b1;
                next_st.chip.wr    = 1'b1;
                next_st.chip.a0    = 1'b1;
                next_st.chip.wdata = io_req_i.wdata;
              end
              `FDHP_PORT_IRQ_DMA:
              begin
                // push: older bytes move up, so msb first ends on top
                next_st.dma_addr = {st.dma_addr[15:0], io_req_i.wdata};
              end
              `FDHP_PORT_SERIAL:
              begin
                next_st.ser_latch = io_req_i.wdata[`FDHP_BIT_D7];
                if (!io_req_i.wdata[`FDHP_BIT_D0])
                begin
                  next_st.rom_en = 1'b0;
                end
              end
              default:
              begin
                next_st.phase = FDHP_ACCESS;
              end
            endcase
          end
        end
      end
      FDHP_ACCESS:
      begin
        // requests in this cycle are ignored; busy shows it
        next_st.phase = FDHP_IDLE;
        if (st.rd_pend)
        begin
          next_st.rdata_valid = 1'b1;
          next_st.rdata       = 8'h00;
          case (st.port)
            `FDHP_PORT_MAIN_STATUS,
            `FDHP_PORT_DATA:
            begin
              next_st.rdata = disk_controller_chip_rdata_i;
            end
            `FDHP_PORT_IRQ_DMA:
            begin
              next_st.rdata[`FDHP_BIT_D7] = disk_chip_irq_i;
            end
            `FDHP_PORT_SERIAL:
            begin
              next_st.rdata[`FDHP_BIT_D7] = serial_rxd_i;
            end
            default:
            begin
              next_st.rdata = 8'h00;
            end
          endcase
        end
        next_st.rd_pend = 1'b0;
      end
      default:
      begin
        next_st.phase = FDHP_IDLE;
      end
    endcase

    // latch one is spacing, so the line level is its inverse;
    // with the motor switch on the line parks at marking
    if (motor_select_switch_on_i)
    begin
      next_st.motor_on = next_st.ser_latch;
      next_st.txd      = 1'b1;
    end
    else
    begin
      next_st.motor_on = 1'b0;
      next_st.txd      = ~next_st.ser_latch;
    end
  end

  // state register; reset leaves the serial line marking, rom on
  always_ff @(posedge mclk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      st           <= '0;
      st.ser_latch <= `FDHP_RST_SER_LATCH;
      st.txd       <= `FDHP_RST_TXD;
      st.rom_en    <= `FDHP_RST_ROM_EN;
    end
    else
    begin
      st <= next_st;
    end
  end

  // poll scanner of the controller chip
  fdhp_drive_scan u_scan
  (
    .mclk_i      (mclk_i),
    .rst_i       (rst_i),
    .drive_sel_o (drive_sel_o),
    .scan_step_o (scan_step_o)
  );

  // outputs straight from the state register
  assign io_rdata_o             = st.rdata;
  assign io_rdata_valid_o       = st.rdata_valid;
  assign io_busy_o              = (st.phase == FDHP_ACCESS);
  assign disk_controller_chip_o = st.chip;
  assign dma_addr_o             = st.dma_addr;
  assign startup_rom_en_o       = st.rom_en;
  assign serial_txd_o           = st.txd;
  assign motor_on_o             = st.motor_on;
  assign vect_irq_o             = st.vect_irq;
  assign gen_irq_o              = st.gen_irq;

endmodule
`default_nettype wire

// [testbench/fdhp_chip_model.sv]
// model of the embedded disk controller chip
`timescale 1ns/1ns
`default_nettype none
module fdhp_chip_model
  import fdhp_pkg::*;
#(
  parameter logic [7:0] STATUS = 8'h5a
)
(
  // clock and chip strobes
  input  wire logic           mclk_i,
  input  wire fdhp_chip_bus_t bus_i,
  output logic [7:0]          rdata_o
);
  logic [7:0] data_q = 8'h00;
  logic [7:0] last = 8'h00;
  // data register takes writes, status is read only
  always @(posedge mclk_i)
  begin
    if (bus_i.cs && bus_i.wr && bus_i.a0) data_q <= bus_i.wdata;
    last <= rdata_o;
  end
  // scrambled when not read, so stale data never passes
  assign rdata_o = (bus_i.cs && bus_i.rd) ? (bus_i.a0 ? data_q : STATUS) : ~last;
endmodule
`default_nettype wire

// [testbench/fdhp_ports_asserts.sv]
// checker of the host port block
`timescale 1ns/1ns
`default_nettype none
module fdhp_ports_chk
  import fdhp_pkg::*;
(
  // watched ports
  input wire logic           mclk_i,
  input wire logic           rst_i,
  input wire fdhp_io_req_t   io_req_i,
  input wire logic           io_busy_o,
  input wire logic           io_rdata_valid_o,
  input wire logic [5:0]     address_switch_bank_on_i,
  input wire logic           motor_select_switch_on_i,
  input wire fdhp_chip_bus_t disk_controller_chip_o,
  input wire logic [23:0]    dma_addr_o,
  input wire logic           startup_rom_en_o,
  input wire logic           serial_txd_o,
  input wire logic           motor_on_o
);
  default clocking @(posedge mclk_i);
  endclocking
  default disable iff (rst_i);
  // taken request, taken write, its port
  logic       rq;
  logic       hit;
  logic       wh;
  logic [1:0] p;
  assign p = io_req_i.addr[1:0];
  assign rq = !io_busy_o && (io_req_i.rd || io_req_i.wr);
  assign hit = rq && io_req_i.addr[7:2] == ~address_switch_bank_on_i;
  assign wh = hit && io_req_i.wr && !io_req_i.rd;
  busy_taken_a: assert property (hit |=> io_busy_o) else $error("no busy");
  miss_ignored_a: assert property (rq && !hit |=> !io_busy_o) else $error("miss taken");
  read_answer_a: assert property (hit && io_req_i.rd |-> ##2 io_rdata_valid_o) else $error("no answer");
  chip_read_a: assert property (hit && io_req_i.rd && !p[1] |=> disk_controller_chip_o.cs
    && disk_controller_chip_o.rd && disk_controller_chip_o.a0 == $past(io_req_i.addr[0])) else $error("chip rd");
  port0_write_a: assert property (wh && p == 2'h0 |=> !disk_controller_chip_o.cs && $stable(dma_addr_o)
    && $stable(serial_txd_o)) else $error("port0 wr");
  dma_push_a: assert property (wh && p == 2'h2 |=> dma_addr_o == {$past(dma_addr_o[15:0]),
    $past(io_req_i.wdata)}) else $error("dma push");
  serial_out_a: assert property (wh && p == 2'h3 && !motor_select_switch_on_i |=> serial_txd_o
    != $past(io_req_i.wdata[7])) else $error("txd");
  motor_out_a: assert property (wh && p == 2'h3 && motor_select_switch_on_i |=> motor_on_o
    == $past(io_req_i.wdata[7]) && serial_txd_o) else $error("motor");
  rom_off_a: assert property (wh && p == 2'h3 && !io_req_i.wdata[0] |=> !startup_rom_en_o) else $error("rom");
  rom_sticky_a: assert property (!startup_rom_en_o |=> !startup_rom_en_o) else $error("rom back");
endmodule
bind fdhp_ports fdhp_ports_chk u_chk (.mclk_i, .rst_i, .io_req_i, .io_busy_o, .io_rdata_valid_o,
  .address_switch_bank_on_i, .motor_select_switch_on_i, .disk_controller_chip_o, .dma_addr_o,
  .startup_rom_en_o, .serial_txd_o, .motor_on_o);
`default_nettype wire

// [testbench/fdhp_ports_bench.sv]
// self-checking bench of the host port block
`timescale 1ns/1ns
`default_nettype none
`include "fdhp_params.svh"
module fdhp_ports_bench
  import fdhp_pkg::*;
;
  logic           mclk_i = 1'b0;
  logic           rst_i = 1'b1;
  fdhp_io_req_t   req = '0;
  logic [5:0]     sw = 6'h0f;
  logic           msw = 1'b0;
  logic [3:0]     route = 4'hf;
  logic           irq = 1'b0;
  logic           rxd = 1'b1;
  fdhp_chip_bus_t chip;
  logic [7:0]     crd, rdata, got, vect;
  logic           valid, busy, txd, motor, rom, gen, step;
  logic [1:0]     sel, s0;
  logic [23:0]    dma;
  int             fail_count = 0;
  int             n_tests = 0;
  int             cyc = 0;
  int             span = 0;
  // port, irq, rxd, expected read data
  logic [11:0]    rows [6] = '{12'h05a, 12'h53c, 12'hb80, 12'h900, 12'hd80, 12'he00};

  always #20 mclk_i = ~mclk_i;

  fdhp_ports dut (.mclk_i(mclk_i), .rst_i(rst_i), .io_req_i(req), .io_rdata_o(rdata),
    .io_rdata_valid_o(valid), .io_busy_o(busy), .address_switch_bank_on_i(sw),
    .motor_select_switch_on_i(msw), .irq_route_sel_i(route), .disk_controller_chip_o(chip),
    .disk_controller_chip_rdata_i(crd), .disk_chip_irq_i(irq), .drive_sel_o(sel),
    .scan_step_o(step), .dma_addr_o(dma), .startup_rom_en_o(rom), .serial_rxd_i(rxd),
    .serial_txd_o(txd), .motor_on_o(motor), .vect_irq_o(vect), .gen_irq_o(gen));
  fdhp_chip_model #(.STATUS(8'h5a)) u_chip (.mclk_i(mclk_i), .bus_i(chip), .rdata_o(crd));

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_tests++;
    if (g !== e)
    begin
      fail_count++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask

  // one host access, spaced as the port allows
  task automatic io(input logic r, input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk_i);
    req <= '{rd: r, wr: !r, addr: a, wdata: d};
    @(posedge mclk_i);
    req.rd <= 1'b0;
    req.wr <= 1'b0;
    @(posedge mclk_i);
    #1 got = rdata;
    if (r) chk(valid, 1'b1);
    @(posedge mclk_i);
  endtask

  task automatic results;
    $display("checks %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // hang guard
  always @(posedge mclk_i)
  begin
    cyc++;
    if (cyc > 20000)
    begin
      fail_count++;
      results;
    end
  end

  initial
  begin
    repeat (4) @(posedge mclk_i);
    rst_i <= 1'b0;
    #1 chk({txd, rom, motor, dma}, {3'b110, 24'h0});
    io(0, 8'hc1, 8'h3c);
    foreach (rows[i])
    begin
      irq <= rows[i][9];
      rxd <= rows[i][8];
      io(1, {6'h30, rows[i][11:10]}, 8'h00);
      chk(got, rows[i][7:0]);
    end
    io(0, 8'hc2, 8'h77);
    io(0, 8'hc2, 8'hf2);
    io(0, 8'hc2, 8'h24);
    io(0, 8'hc2, 8'h52);
    chk(dma, 24'hf22452);
    io(0, 8'hc3, 8'h81);
    chk({txd, rom}, 2'b01);
    io(0, 8'hc0, 8'h00);
    io(0, 8'hc7, 8'h00);
    chk({txd, rom, dma}, {2'b01, 24'hf22452});
    io(0, 8'hc3, 8'h00);
    chk({txd, rom}, 2'b10);
    sw <= 6'h0c;
    io(0, 8'hcf, 8'h81);
    chk({txd, rom}, 2'b00);
    msw <= 1'b1;
    io(0, 8'hcf, 8'h01);
    chk({motor, txd}, 2'b01);
    io(0, 8'hcf, 8'h80);
    chk({motor, txd}, 2'b11);
    route <= 4'h3;
    irq <= 1'b1;
    repeat (3) @(posedge mclk_i);
    #1 chk({gen, vect}, 9'h008);
    @(posedge mclk_i);
    route <= 4'h8;
    repeat (3) @(posedge mclk_i);
    #1 chk({gen, vect}, 9'h100);
    // wait for a select change, then time one full poll step
    s0 = sel;
    repeat (2600) if (sel === s0) @(posedge mclk_i) #1;
    chk({step, sel}, {1'b1, 2'(s0 + 2'h1)});
    s0 = sel;
    while (sel === s0 && span < 2600)
    begin
      @(posedge mclk_i) #1;
      span++;
    end
    chk(span, `FDHP_SCAN_CYCLES);
    @(posedge mclk_i);
    msw <= 1'b0;
    rxd <= 1'b1;
    rst_i <= 1'b1;
    @(posedge mclk_i);
    rst_i <= 1'b0;
    #1 chk({txd, rom, motor}, 3'b110);
    repeat (2) @(posedge mclk_i);
    #1 chk({txd, rom, motor, dma}, {3'b110, 24'h0});
    io(1, 8'hcf, 8'h00);
    chk(got, 8'h80);
    results;
  end
endmodule
`default_nettype wire
